// *** card_ctl_cfg.svh ***
/*
 Constants for the 16-bit card control-signal block: battery codes, timing.
 Assumes a 25 MHz controller clock.
*/
`ifndef CARD_CTL_CFG_SVH
`define CARD_CTL_CFG_SVH
`define CLK_PERIOD_NS 40
`define IORD_PULSE_NS 165
`define IORD_PULSE_CYC ((`IORD_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IORD_CNT_W 4
`define BATT_GOOD 2'h0
`define BATT_WEAK 2'h1
`define BATT_DEAD 2'h2
`endif

// *** card_ctl_pkg.sv ***
/*
 Types shared by the card control-signal block.
 Assumes card_ctl_cfg.svh supplies the numeric codes.
*/
package card_ctl_pkg;
    typedef logic [1:0] batt_t;
endpackage

// *** pin_sync.sv ***
/*
 Two-flop synchroniser for a group of card pins.
 Assumes inputs are asynchronous to clk.
*/
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pins in, synchronised out
    input wire logic [W-1:0] pin,
    output logic [W-1:0] sync
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= INIT;
            sync <= INIT;
        end
        else
        begin
            meta_q <= pin;
            sync <= meta_q;
        end
    end
endmodule

// *** card_ctl.sv ***
// What this block does
// [R1] Both battery inputs high means good; second low, first high means weak.
// [R2] First battery input low means dead battery, memory contents lost.
// [R3] I/O card uses first battery input as status-change alert.
// [R4] Modem card uses first battery input to signal ring detection.
// [R5] Second battery input carries speaker audio only in I/O interface mode.
// [R6] Card-detect levels are sensed and reported as status.
// [R7] First card enable selects even bytes, second selects odd bytes.
// [R8] Card asserts input acknowledge when it can answer the I/O read.
// [R9] I/O read strobe asserted toward card during host I/O read cycles.
// [R10] Card present only when both card-detect inputs are low.
/*
 Control-signal side of a 16-bit card socket: battery decode, status-change,
 ring, speaker, card detect, byte card enables and I/O read strobe.
 Assumes the host issues one I/O read request pulse at a time on clk.
*/
`timescale 1ns/10ps
`include "card_ctl_cfg.svh"
module card_ctl #(
    parameter int PULSE_CYC = `IORD_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Socket mode
    input wire logic io_mode,
    // Card status pins (all active low except battery levels)
    input wire logic bvd1,
    input wire logic bvd2,
    input wire logic cd1_b,
    input wire logic cd2_b,
    input wire logic inpack_b,
    // Host I/O read request
    input wire logic rd_req,
    input wire logic [1:0] rd_bytes,
    // Status out
    output logic card_present_q,
    output logic card_partial_q,
    output card_ctl_pkg::batt_t batt_state_q,
    output logic stschg_q,
    output logic ring_q,
    output logic spkr_q,
    output logic inpack_seen_q,
    output logic rd_busy_q,
    // Card strobes (active low)
    output logic ce1_b_q,
    output logic ce2_b_q,
    output logic iord_b_q
);
    logic [4:0] pins_s;
    logic bvd1_s, bvd2_s, cd1_s, cd2_s, inpack_s;

    pin_sync #(.W(5), .INIT(5'h1F)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin({bvd1, bvd2, cd1_b, cd2_b, inpack_b}),
        .sync(pins_s)
    );
    assign {bvd1_s, bvd2_s, cd1_s, cd2_s, inpack_s} = pins_s;

    // Status decode
    logic card_present_d, card_partial_d, stschg_d, ring_d, spkr_d;
    card_ctl_pkg::batt_t batt_state_d;

    always_comb
    begin
        card_present_d = !cd1_s && !cd2_s; // [R10] [R6]
        card_partial_d = cd1_s ^ cd2_s; // [R10]
        batt_state_d = `BATT_GOOD; // [R1]
        stschg_d = 1'b0;
        ring_d = 1'b0;
        spkr_d = 1'b0;
        if (!card_present_d)
        begin
            batt_state_d = `BATT_GOOD;
        end
        else if (io_mode)
        begin
            // Low on the first input is the alert in I/O mode
            stschg_d = !bvd1_s; // [R3]
            ring_d = !bvd1_s; // [R4]
            spkr_d = bvd2_s; // [R5]
        end
        else if (!bvd1_s)
        begin
            batt_state_d = `BATT_DEAD; // [R2]
        end
        else if (!bvd2_s)
        begin
            batt_state_d = `BATT_WEAK; // [R1]
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            card_present_q <= 1'b0;
            card_partial_q <= 1'b0;
            batt_state_q <= `BATT_GOOD;
            stschg_q <= 1'b0;
            ring_q <= 1'b0;
            spkr_q <= 1'b0;
        end
        else
        begin
            card_present_q <= card_present_d;
            card_partial_q <= card_partial_d;
            batt_state_q <= batt_state_d;
            stschg_q <= stschg_d;
            ring_q <= ring_d;
            spkr_q <= spkr_d;
        end
    end

    // I/O read cycle
    typedef enum logic [0:0] {IDLE, READ} rd_state_t;
    rd_state_t st_q, st_d;
    logic [`IORD_CNT_W-1:0] cnt_q, cnt_d;
    logic ce1_b_d, ce2_b_d, iord_b_d, inpack_seen_d, rd_busy_d;

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        ce1_b_d = ce1_b_q;
        ce2_b_d = ce2_b_q;
        iord_b_d = iord_b_q;
        inpack_seen_d = inpack_seen_q;
        case (st_q)
            IDLE:
            begin
                // A request with no card seated is dropped
                if (rd_req && card_present_q && rd_bytes != 2'h0)
                begin
                    st_d = READ;
                    cnt_d = `IORD_CNT_W'(PULSE_CYC - 1);
                    ce1_b_d = !rd_bytes[0]; // [R7]
                    ce2_b_d = !rd_bytes[1]; // [R7]
                    iord_b_d = 1'b0; // [R9]
                    inpack_seen_d = 1'b0;
                end
            end
            READ:
            begin
                // The ack path lags two edges, so earlier samples belong to the previous read
                if (!inpack_s && cnt_q <= `IORD_CNT_W'(PULSE_CYC - 3))
                begin
                    inpack_seen_d = 1'b1; // [R8]
                end
                if (cnt_q == `IORD_CNT_W'(0))
                begin
                    st_d = IDLE;
                    ce1_b_d = 1'b1;
                    ce2_b_d = 1'b1;
                    iord_b_d = 1'b1;
                end
                else
                begin
                    cnt_d = cnt_q - `IORD_CNT_W'(1);
                end
            end
            default:
            begin
                st_d = IDLE;
            end
        endcase
        rd_busy_d = (st_d == READ);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= IDLE;
            cnt_q <= '0;
            ce1_b_q <= 1'b1;
            ce2_b_q <= 1'b1;
            iord_b_q <= 1'b1;
            inpack_seen_q <= 1'b0;
            rd_busy_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ce1_b_q <= ce1_b_d;
            ce2_b_q <= ce2_b_d;
            iord_b_q <= iord_b_d;
            inpack_seen_q <= inpack_seen_d;
            rd_busy_q <= rd_busy_d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    present_both_a: assert property (card_present_q |-> $past(!cd1_s && !cd2_s)) // [R10]
        else $error("present without both detects low");
    partial_flag_a: assert property (card_partial_q |-> !card_present_q) // [R6]
        else $error("partial and present together");
    batt_dead_a: assert property ($past(card_present_d && !io_mode && !bvd1_s) |-> batt_state_q == `BATT_DEAD) // [R2]
        else $error("dead battery not reported");
    batt_weak_a: assert property ($past(card_present_d && !io_mode && bvd1_s && !bvd2_s)
        |-> batt_state_q == `BATT_WEAK) // [R1]
        else $error("weak battery not reported");
    batt_good_a: assert property ($past(card_present_d && !io_mode && bvd1_s && bvd2_s)
        |-> batt_state_q == `BATT_GOOD) // [R1]
        else $error("good battery not reported");
    spkr_gate_a: assert property (spkr_q |-> $past(io_mode)) // [R5]
        else $error("speaker outside I/O mode");
    stschg_src_a: assert property ($past(card_present_d && io_mode) |-> stschg_q == $past(!bvd1_s)) // [R3]
        else $error("status change not following pin");
    ring_src_a: assert property (ring_q |-> $past(card_present_d && io_mode && !bvd1_s)) // [R4]
        else $error("ring without first input low");
    iord_start_a: assert property ($rose(rd_busy_q) |-> !iord_b_q && (ce1_b_q == !$past(rd_bytes[0]))) // [R9]
        else $error("read strobe or enable wrong at start");
    ce_odd_a: assert property ($rose(rd_busy_q) |-> ce2_b_q == !$past(rd_bytes[1])) // [R7]
        else $error("odd byte enable wrong");
    iord_len_a: assert property ($fell(iord_b_q) |-> !iord_b_q [*5] ##1 iord_b_q) // [R9]
        else $error("read strobe length wrong");
    strobe_idle_a: assert property (iord_b_q |-> ce1_b_q && ce2_b_q) // [R7]
        else $error("card enable without read");

    rd_even_c: cover property ($rose(rd_busy_q) && !ce1_b_q && ce2_b_q);
    rd_word_c: cover property ($rose(rd_busy_q) && !ce1_b_q && !ce2_b_q);
    ack_c: cover property ($rose(inpack_seen_q));
    dead_c: cover property (batt_state_q == `BATT_DEAD);
endmodule

// *** card_model.sv ***
/*
 Behavioural 16-bit card seated in the socket: detect, battery and ack pins.
 Assumes the bench sets seating, pin levels and whether reads are acknowledged.
*/
`timescale 1ns/10ps
module card_model (
    // Bench controls
    input wire logic [1:0] seat_b,
    input wire logic [1:0] batt,
    input wire logic ack_en,
    // Socket pins
    input wire logic iord_b,
    output logic bvd1,
    output logic bvd2,
    output logic cd1_b,
    output logic cd2_b,
    output logic inpack_b
);
    assign cd1_b = seat_b[0];
    assign cd2_b = seat_b[1];
    // Same pin is battery, status-change or ring depending on card type
    assign bvd1 = batt[0];
    assign bvd2 = batt[1];
    // Acknowledge only while the read strobe is low, released high otherwise
    assign inpack_b = !(ack_en && !iord_b);
endmodule

// *** card_ctl_tb.sv ***
/*
 Self-checking bench for card_ctl with a behavioural card model.
 Assumes card_ctl_cfg.svh and card_ctl_pkg are compiled first.
*/
`timescale 1ns/10ps
`include "card_ctl_cfg.svh"
module card_ctl_tb;
    logic clk, rst_b, io_mode, rd_req, ack_en;
    logic [1:0] rd_bytes, seat_b, batt;
    logic bvd1, bvd2, cd1_b, cd2_b, inpack_b;
    logic present, partial, stschg, ring, spkr, seen, busy, ce1_b, ce2_b, iord_b;
    card_ctl_pkg::batt_t batt_state;
    int failures, checked;
    card_ctl #(.PULSE_CYC(5)) u_card_ctl (.clk(clk), .rst_b(rst_b), .io_mode(io_mode), .bvd1(bvd1),
        .bvd2(bvd2), .cd1_b(cd1_b), .cd2_b(cd2_b), .inpack_b(inpack_b), .rd_req(rd_req),
        .rd_bytes(rd_bytes), .card_present_q(present), .card_partial_q(partial),
        .batt_state_q(batt_state), .stschg_q(stschg), .ring_q(ring), .spkr_q(spkr),
        .inpack_seen_q(seen), .rd_busy_q(busy), .ce1_b_q(ce1_b), .ce2_b_q(ce2_b), .iord_b_q(iord_b));
    card_model u_card_model (.seat_b(seat_b), .batt(batt), .ack_en(ack_en), .iord_b(iord_b),
        .bvd1(bvd1), .bvd2(bvd2), .cd1_b(cd1_b), .cd2_b(cd2_b), .inpack_b(inpack_b));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task chk(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task finish_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Status settles three edges after a pin change; one spare edge
    task set_pins(input logic [1:0] s, input logic [1:0] b, input logic io);
        @(posedge clk);
        seat_b <= s;
        batt <= b;
        io_mode <= io;
        cyc(4);
    endtask
    task t_detect;
        chk({present, partial, iord_b, ce1_b}, 4'h3);
        set_pins(2'h2, 2'h3, 1'b0);
        chk({present, partial}, 2'h1);
        set_pins(2'h0, 2'h3, 1'b0);
        chk({present, partial}, 2'h2);
    endtask
    task t_batt;
        for (int i = 3; i >= 0; i--)
        begin
            set_pins(2'h0, i[1:0], 1'b0);
            chk(batt_state, !i[0] ? `BATT_DEAD : !i[1] ? `BATT_WEAK : `BATT_GOOD);
        end
    endtask
    task t_io;
        set_pins(2'h0, 2'h2, 1'b1);
        chk({stschg, ring, spkr, batt_state[0]}, 4'hE);
        set_pins(2'h0, 2'h1, 1'b1);
        chk({stschg, ring, spkr, batt_state[1]}, 4'h0);
    endtask
    task t_read(input logic [1:0] bytes, input logic ack);
        int n;
        @(posedge clk);
        rd_req <= 1'b1;
        rd_bytes <= bytes;
        ack_en <= ack;
        @(posedge clk);
        rd_req <= 1'b0;
        #1;
        // No byte selected or no card seated: the request must be dropped
        if (bytes == 2'h0 || seat_b != 2'h0)
        begin
            chk({iord_b, ce2_b, ce1_b, busy}, 4'hE);
            return;
        end
        chk({iord_b, ce2_b, ce1_b, busy}, {1'b0, ~bytes[1], ~bytes[0], 1'b1});
        n = 0;
        while (iord_b === 1'b0 && n < 20)
        begin
            cyc(1);
            n++;
        end
        if (n == 20)
        begin
            failures++;
            finish_test();
        end
        else
        begin
            chk(n[3:0], 4'h5);
            chk({seen, busy, ce1_b, ce2_b}, {ack, 3'h3});
        end
    endtask
    // Mid-run reset: strobes and status drop at once, status returns via the synchronisers
    task t_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        cyc(1);
        chk({present, stschg, spkr, iord_b}, 4'h1);
        @(posedge clk);
        rst_b <= 1'b1;
        cyc(4);
        chk({present, partial, batt_state}, 4'h8);
    endtask
    task t_nocard;
        set_pins(2'h3, 2'h3, 1'b1);
        chk({present, partial}, 2'h0);
        t_read(2'h3, 1'b1);
    endtask
    initial
    begin
        failures = 0;
        checked = 0;
        rst_b = 1'b0;
        io_mode = 1'b0;
        rd_req = 1'b0;
        rd_bytes = 2'h0;
        ack_en = 1'b0;
        seat_b = 2'h3;
        batt = 2'h3;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        cyc(1);
        t_detect();
        t_batt();
        t_io();
        t_read(2'h1, 1'b1);
        t_read(2'h2, 1'b0);
        t_read(2'h3, 1'b1);
        t_read(2'h0, 1'b1);
        t_reset();
        t_nocard();
        finish_test();
    end
endmodule
